/* File: core/back_emf_pkg.sv */
// Purpose: Shared constants for the back-EMF zero-cross and PWM block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
package back_emf_pkg;

  // Register byte offsets
  localparam logic [7:0]  OFS_CMP_CTL  = 8'h00;
  localparam logic [7:0]  OFS_COMM_TMR = 8'h04;
  localparam logic [7:0]  OFS_PWM_PER  = 8'h08;
  localparam logic [7:0]  OFS_PWM_DUTY = 8'h0c;
  localparam logic [7:0]  OFS_PWM_CTL  = 8'h10;
  localparam logic [7:0]  OFS_INT_STAT = 8'h14;
  localparam logic [7:0]  OFS_INT_MASK = 8'h18;

  // Comparator control fields
  localparam int          CMP_LIVE_BIT = 0;
  localparam int          CMP_HOLD_BIT = 1;
  localparam int          CMP_SEL_LSB  = 2;
  localparam int          CMP_TEMP_BIT = 4;

  // PWM control fields
  localparam int          DLOW_LSB     = 0;
  localparam int          PWM_EN_BIT   = 2;

  // Interrupt bits
  localparam int          INT_W        = 3;
  localparam int          INT_ZC       = 0;
  localparam int          INT_COMM     = 1;
  localparam int          INT_PWM      = 2;

  // Values after reset
  localparam logic [7:0]  PER_RST      = 8'hff;
  localparam logic [7:0]  DUTY_RST     = 8'h00;
  localparam logic [1:0]  DLOW_RST     = 2'h0;
  localparam logic [15:0] TMR_RST      = 16'h0000;
  localparam logic [1:0]  SEL_RST      = 2'h0;
  localparam logic [2:0]  MASK_RST     = 3'h0;

  // Quarter-rate tick: count advances when the prescaler is at its last step
  localparam logic [1:0]  PRE_LAST     = 2'h3;
  localparam logic [15:0] TMR_LAST     = 16'hffff;

endpackage

/* File: core/pwm_link_if.sv */
// Purpose: Carries PWM settings and status between register file and generator
// Assumes: Single pclk domain
// Notes:   duty holds the 10-bit on-time
`timescale 1ns/1ns
`default_nettype none
interface pwm_link_if;
  logic [7:0] period;
  logic [9:0] duty;
  logic       en;
  logic       tick;
  logic       period_start;
  logic       pwm_out;
  modport ctl (output period, duty, en, input tick, period_start, pwm_out);
  modport gen (input period, duty, en, output tick, period_start, pwm_out);
endinterface
`default_nettype wire

/* File: core/pwm_gen.sv */
// Purpose: PWM time base with quarter-rate count and 10-bit duty compare
// Assumes: Settings from the register file through pwm_link_if
// Notes:   Prescaler bits act as the two fine duty bits
`timescale 1ns/1ns
`default_nettype none
module pwm_gen
  import back_emf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Link to register file
  pwm_link_if.gen  lnk
);

  logic [1:0] pre_r;
  logic [7:0] tb_r;
  logic       out_r;
  logic [8:0] tb_inc;
  logic [9:0] cnt;
  logic       wrap;

  assign tb_inc   = {1'b0, tb_r} + 9'h001;
  assign lnk.tick = lnk.en && (pre_r == PRE_LAST);
  assign wrap     = lnk.tick && (tb_inc == {1'b0, lnk.period});
  assign cnt      = {tb_r, pre_r};
  assign lnk.period_start = wrap;
  assign lnk.pwm_out      = out_r;

  // Prescaler steps every clock while PWM is enabled, so its bits are the fine duty steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 2'h0;
    end else if (ce) begin
      pre_r <= lnk.en ? pre_r + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_r <= 8'h00;
    end else if (ce) begin
      if (!lnk.en || wrap) begin
        tb_r <= 8'h00;
      end else if (lnk.tick) begin
        tb_r <= tb_inc[7:0];
      end
    end
  end

  // High at period start, low once the 10-bit count meets the duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 1'b0;
    end else if (ce) begin
      if (!lnk.en || cnt == lnk.duty) begin
        out_r <= 1'b0;
      end else if (cnt == 10'h000) begin
        out_r <= 1'b1;
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TB_WRAP: assert property (ce && wrap |=> tb_r == 8'h00)
    else $error("time base did not wrap at period");
  AST_TB_RATE: assert property (ce && lnk.en && pre_r == 2'h0 ##1 ce[*3] |-> lnk.tick)
    else $error("time base tick not every fourth clock");
  AST_PWM_LOW: assert property (ce && lnk.en && cnt == lnk.duty |=> !out_r)
    else $error("pwm not low at duty match");
  AST_PWM_HIGH: assert property (ce && lnk.en && cnt == 10'h000 && lnk.duty != 10'h000 |=> out_r)
    else $error("pwm not high at period start");

endmodule
`default_nettype wire

/* File: core/back_emf_ctl.sv */
// Purpose: Zero-cross mismatch capture, commutation timer, PWM registers
// Assumes: APB slave, zero wait states, comparator input synchronous to pclk
// Notes:   Counters tick at one quarter of pclk while PWM is enabled
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none

module back_emf_ctl
  import back_emf_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,

  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,

  // Motor side
  input  wire logic        comp_in,
  output var  logic [1:0]  comp_sel,
  output logic             pwm_out,

  // Interrupt
  output logic             irq
);

  pwm_link_if lnk ();

  logic              acc;
  logic              wr;
  logic              hit;
  logic              cmp_acc;
  logic              tmr_wr;
  logic              comm_ovf;
  logic              mismatch;
  logic [INT_W-1:0]  ev_set;
  logic [INT_W-1:0]  ev_clr;
  logic [31:0]       rdata_nxt;

  logic              temp_r;
  logic              hold_r;
  logic [1:0]        sel_r;
  logic [15:0]       tmr_r;
  logic [7:0]        per_r;
  logic [7:0]        duty_r;
  logic [1:0]        dlow_r;
  logic              en_r;
  logic [INT_W-1:0]  stat_r;
  logic [INT_W-1:0]  mask_r;

  // Bus decode
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign pready  = 1'b1;

  always_comb begin
    unique case (paddr)
      OFS_CMP_CTL, OFS_COMM_TMR, OFS_PWM_PER, OFS_PWM_DUTY,
      OFS_PWM_CTL, OFS_INT_STAT, OFS_INT_MASK: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  assign pslverr = acc && !hit;
  assign cmp_acc = acc && (paddr == OFS_CMP_CTL);
  assign tmr_wr  = wr && (paddr == OFS_COMM_TMR);

  // Mismatch latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_r <= 1'b0;
    end else if (ce) begin
      temp_r <= comp_in;
    end
  end

  // Either direction of access re-arms the holding latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 1'b0;
    end else if (ce && cmp_acc) begin
      hold_r <= comp_in;
    end
  end

  assign mismatch = hold_r ^ temp_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= SEL_RST;
    end else if (ce && wr && paddr == OFS_CMP_CTL) begin
      sel_r <= pwdata[CMP_SEL_LSB +: 2];
    end
  end

  assign comp_sel = sel_r;

  // Commutation timer: software presets a negative count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_r <= TMR_RST;
    end else if (ce) begin
      if (tmr_wr) begin
        tmr_r <= pwdata[15:0];
      end else if (lnk.tick) begin
        tmr_r <= tmr_r + 16'h0001;
      end
    end
  end

  assign comm_ovf = lnk.tick && !tmr_wr && (tmr_r == TMR_LAST);

  // PWM settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_r <= PER_RST;
    end else if (ce && wr && paddr == OFS_PWM_PER) begin
      per_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_r <= DUTY_RST;
    end else if (ce && wr && paddr == OFS_PWM_DUTY) begin
      duty_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlow_r <= DLOW_RST;
      en_r   <= 1'b0;
    end else if (ce && wr && paddr == OFS_PWM_CTL) begin
      dlow_r <= pwdata[DLOW_LSB +: 2];
      en_r   <= pwdata[PWM_EN_BIT];
    end
  end

  assign lnk.period = per_r;
  assign lnk.duty   = {duty_r, dlow_r};
  assign lnk.en     = en_r;
  assign pwm_out    = lnk.pwm_out;

  pwm_gen u_pwm (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .lnk     (lnk)
  );

  // Sticky status: a new event wins over a clear in the same cycle
  assign ev_set = {lnk.period_start, comm_ovf, mismatch};

  always_comb begin
    ev_clr = '0;
    if (wr && paddr == OFS_INT_STAT) begin
      ev_clr = pwdata[INT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else if (ce) begin
      stat_r <= (stat_r & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= MASK_RST;
    end else if (ce && wr && paddr == OFS_INT_MASK) begin
      mask_r <= pwdata[INT_W-1:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  // Read data
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      OFS_CMP_CTL: begin
        rdata_nxt[CMP_LIVE_BIT]          = comp_in;
        rdata_nxt[CMP_HOLD_BIT]          = hold_r;
        rdata_nxt[CMP_SEL_LSB +: 2]      = sel_r;
        rdata_nxt[CMP_TEMP_BIT]          = temp_r;
      end
      OFS_COMM_TMR: begin
        rdata_nxt[15:0] = tmr_r;
      end
      OFS_PWM_PER: begin
        rdata_nxt[7:0] = per_r;
      end
      OFS_PWM_DUTY: begin
        rdata_nxt[7:0] = duty_r;
      end
      OFS_PWM_CTL: begin
        rdata_nxt[DLOW_LSB +: 2] = dlow_r;
        rdata_nxt[PWM_EN_BIT]    = en_r;
      end
      OFS_INT_STAT: begin
        rdata_nxt[INT_W-1:0] = stat_r;
      end
      OFS_INT_MASK: begin
        rdata_nxt[INT_W-1:0] = mask_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Read data is captured in the setup cycle and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      prdata <= rdata_nxt;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_MISMATCH_IRQ: assert property (ce && hold_r != temp_r |=> stat_r[INT_ZC])
    else $error("latch mismatch did not flag zero-cross");

  AST_HOLD_LOAD: assert property (ce && cmp_acc |=> hold_r == $past(comp_in))
    else $error("holding latch not loaded on access");

  AST_TEMP_CHANGE: assert property (
    ce && !cmp_acc && comp_in != hold_r ##1 ce && !cmp_acc |=> stat_r[INT_ZC])
    else $error("comparator change not caught as mismatch");

  AST_COMM_OVF: assert property (
    ce && comm_ovf |=> tmr_r == TMR_RST && stat_r[INT_COMM])
    else $error("timer overflow did not raise commutation event");

  // A clear only sticks once the latches agree again
  AST_ZC_CLEAR: assert property (
    ce && wr && paddr == OFS_INT_STAT && pwdata[INT_ZC] && !mismatch |=> !stat_r[INT_ZC])
    else $error("zero-cross status not cleared by write of one");

  // Clock enable low freezes latches, status and timer
  AST_FREEZE: assert property (
    !ce |=> $stable(hold_r) && $stable(temp_r) && $stable(stat_r) && $stable(tmr_r))
    else $error("state changed while clock enable low");

  AST_PER_HOLD: assert property (
    !(ce && wr && paddr == OFS_PWM_PER) |=> $stable(per_r))
    else $error("period register changed without a write");

endmodule
`default_nettype wire

/* File: testbench/motor_model.sv */
// Purpose: Motor sense dividers and comparator feeding comp_in
// Assumes: Select 3 is the reference, which reads low
// Notes:   Phase levels are set by the bench
`timescale 1ns/1ns
`default_nettype none
module motor_model (
  // Clock
  input  wire logic       pclk,
  // Bench control
  input  wire logic [2:0] phase_lvl,
  input  wire logic [1:0] comp_sel,
  // Comparator
  output var  logic       comp_in
);
  initial comp_in = 1'b0;
  // Comparator settles one clock after a phase change
  always @(posedge pclk) begin
    comp_in <= (comp_sel == 2'h3) ? 1'b0 : phase_lvl[comp_sel];
  end
endmodule
`default_nettype wire

/* File: testbench/tb_back_emf_zero_cross_commutation.sv */
// Purpose: Self-checking bench for back_emf_ctl
// Assumes: Zero-wait APB, ce held high except in the clock enable case
// Notes:   Register rows first, then crossing, PWM and timer cases
`timescale 1ns/1ns
`default_nettype none
module tb_back_emf_zero_cross_commutation;
  import back_emf_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        comp_in;
  logic [1:0]  comp_sel;
  logic        pwm_out;
  logic        irq;
  logic [2:0]  phase_lvl;
  logic [31:0] rd;
  logic        er;
  int          error_cnt;
  int          samples_checked;
  int          hi;
  int          per;
  // Write flag, address, write data, expected read data
  logic [72:0] rows [13] = '{
    {1'b0, OFS_PWM_PER, 32'h0, 32'hff}, {1'b0, OFS_PWM_DUTY, 32'h0, 32'h0},
    {1'b0, OFS_PWM_CTL, 32'h0, 32'h0}, {1'b0, OFS_INT_MASK, 32'h0, 32'h0},
    {1'b0, OFS_COMM_TMR, 32'h0, 32'h0}, {1'b0, OFS_INT_STAT, 32'h0, 32'h0},
    {1'b0, 8'h1c, 32'h0, 32'h0}, {1'b1, OFS_PWM_PER, 32'hffffff55, 32'h0},
    {1'b0, OFS_PWM_PER, 32'h0, 32'h55}, {1'b1, OFS_PWM_DUTY, 32'ha5, 32'h0},
    {1'b0, OFS_PWM_DUTY, 32'h0, 32'ha5}, {1'b1, OFS_PWM_CTL, 32'h3, 32'h0},
    {1'b0, OFS_PWM_CTL, 32'h0, 32'h3}};

  back_emf_ctl i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_in(comp_in),
    .comp_sel(comp_sel), .pwm_out(pwm_out), .irq(irq));
  motor_model i_motor (.pclk(pclk), .phase_lvl(phase_lvl), .comp_sel(comp_sel),
    .comp_in(comp_in));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic hang(input int k);
    if (k >= 100) begin
      error_cnt++;
      $display("unexpected wait exp done got timeout");
      stop_test();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    hang(k);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    hang(k);
  endtask

  task automatic meas(output int h, output int p);
    int k;
    k = 0;
    while (pwm_out !== 1'b0 && k < 100) begin @(posedge pclk); k++; end
    while (pwm_out !== 1'b1 && k < 100) begin @(posedge pclk); k++; end
    h = 0;
    while (pwm_out === 1'b1 && k < 100) begin @(posedge pclk); h++; k++; end
    p = h;
    while (pwm_out !== 1'b1 && k < 100) begin @(posedge pclk); p++; k++; end
    hang(k);
  endtask

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    phase_lvl = 3'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i][72], rows[i][71:64], rows[i][63:32], rd, er);
      if (!rows[i][72]) chk("read data", rows[i][31:0], rd);
      chk("slave error", {31'h0, rows[i][71:64] > OFS_INT_MASK}, {31'h0, er});
    end
    $display("test registers done");
    // Zero-cross capture on phase 1
    apb(1'b1, OFS_CMP_CTL, 32'h4, rd, er);
    apb(1'b1, OFS_INT_MASK, 32'h1, rd, er);
    apb(1'b1, OFS_INT_STAT, 32'h7, rd, er);
    apb(1'b0, OFS_CMP_CTL, 32'h0, rd, er);
    chk("phase select", 32'h4, rd & 32'hc);
    phase_lvl <= 3'h4;
    repeat (4) @(posedge pclk);
    chk("irq quiet", 32'h0, {31'h0, irq});
    phase_lvl <= 3'h6;
    wait_irq();
    chk("irq crossing", 32'h1, {31'h0, irq});
    apb(1'b0, OFS_CMP_CTL, 32'h0, rd, er);
    chk("live level", 32'h1, rd & 32'h1);
    apb(1'b1, OFS_INT_STAT, 32'h1, rd, er);
    apb(1'b0, OFS_INT_STAT, 32'h0, rd, er);
    chk("crossing status", 32'h0, rd & 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test zero cross done");
    // PWM period 4, duty 2, every fine duty step
    apb(1'b1, OFS_PWM_PER, 32'h4, rd, er);
    apb(1'b1, OFS_PWM_DUTY, 32'h2, rd, er);
    for (int lo = 0; lo < 4; lo++) begin
      apb(1'b1, OFS_PWM_CTL, 32'h4 | 32'(lo), rd, er);
      meas(hi, per);
      chk("high time", 32'(8 + lo), 32'(hi));
      chk("period", 32'd16, 32'(per));
    end
    $display("test pwm done");
    // Commutation timer overflow
    apb(1'b1, OFS_INT_MASK, 32'h2, rd, er);
    apb(1'b1, OFS_INT_STAT, 32'h7, rd, er);
    apb(1'b1, OFS_COMM_TMR, 32'hfffe, rd, er);
    chk("irq before wrap", 32'h0, {31'h0, irq});
    wait_irq();
    apb(1'b0, OFS_INT_STAT, 32'h0, rd, er);
    chk("overflow status", 32'h2, rd & 32'h2);
    $display("test timer done");
    // Reset in mid-run restores the period and quiets the interrupt
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_PWM_PER, 32'h0, rd, er);
    chk("period after reset", {24'h0, PER_RST}, rd);
    chk("irq after reset", 32'h0, {31'h0, irq});
    $display("test reset done");
    // Clock enable low: a write is not taken
    ce <= 1'b0;
    apb(1'b1, OFS_PWM_PER, 32'h77, rd, er);
    ce <= 1'b1;
    apb(1'b0, OFS_PWM_PER, 32'h0, rd, er);
    chk("period frozen", {24'h0, PER_RST}, rd);
    $display("test clock enable done");
    stop_test();
  end
endmodule
`default_nettype wire
